// ### core/cies_pkg.sv
// Shared constants, types and helper functions of the instruction execution core.
`default_nettype none
package cies_pkg;
	// Register byte offsets.
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_WORK   = 8'h08;
	localparam logic [7:0] ADDR_BANK   = 8'h0C;
	localparam logic [7:0] ADDR_PC     = 8'h10;
	localparam logic [7:0] ADDR_SHADOW = 8'h14;
	localparam logic [7:0] ADDR_STACK  = 8'h18;
	localparam logic [7:0] ADDR_CORE   = 8'h1C;
	localparam logic [7:0] ADDR_BASE   = 8'h20;
	// Reset values.
	localparam logic [1:0]  RST_CTRL   = 2'h0;
	localparam logic [7:0]  RST_STATUS = 8'h00;
	localparam logic [7:0]  RST_WORK   = 8'h00;
	localparam logic [3:0]  RST_BANK   = 4'h0;
	localparam logic [11:0] RST_BASE   = 12'h000;
	localparam logic [20:0] RST_PC     = 21'h000000;
	localparam logic        RST_FLAG   = 1'b1;
	// Field positions.
	localparam int CTRL_RUN = 0;
	localparam int CTRL_EXT = 1;
	localparam int ST_ZERO  = 2;
	localparam int ST_OVF   = 3;
	localparam int CORE_EXP = 0;
	localparam int CORE_PWR = 1;
	// Opcode patterns.
	localparam logic [3:0]  OPC_TOGGLE  = 4'h7;
	localparam logic [7:0]  OPC_BR_OVF  = 8'hE4;
	localparam logic [7:0]  OPC_BR_ZERO = 8'hE0;
	localparam logic [6:0]  OPC_CALL    = 7'h76;
	localparam logic [6:0]  OPC_CLEAR   = 7'h35;
	localparam logic [15:0] OPC_CLR_WDG = 16'h0004;
	localparam logic [15:0] NOP_WORD    = 16'h0000;
	// Addressing and program counter steps.
	localparam logic [7:0]  LIT_OFS_MAX = 8'h5F;
	localparam logic [7:0]  ACC_SPLIT   = 8'h60;
	localparam logic [3:0]  ACC_HI_BANK = 4'hF;
	localparam logic [20:0] PC_STEP     = 21'h000002;
	localparam logic [20:0] RET_OFS     = 21'h000004;
	// Watchdog and stack sizes.
	localparam int WDG_CNT_W   = 16;
	localparam int WDG_POST_W  = 8;
	localparam int STACK_DEPTH = 31;

	typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} cies_phase_e;
	typedef enum logic [2:0] {
		OP_NONE,
		OP_BIT_TOGGLE,
		OP_BR_OVF,
		OP_BR_ZERO,
		OP_CALL,
		OP_CLEAR_FILE,
		OP_CLEAR_WDG
	} cies_op_e;

	// Classifies an instruction word.
	function automatic cies_op_e decode(input logic [15:0] w);
		if (w[15:12] == OPC_TOGGLE) return OP_BIT_TOGGLE;
		else if (w[15:8] == OPC_BR_OVF) return OP_BR_OVF;
		else if (w[15:8] == OPC_BR_ZERO) return OP_BR_ZERO;
		else if (w[15:9] == OPC_CALL) return OP_CALL;
		else if (w[15:9] == OPC_CLEAR) return OP_CLEAR_FILE;
		else if (w == OPC_CLR_WDG) return OP_CLEAR_WDG;
		else return OP_NONE;
	endfunction

	// Forms the data address from the access flag and register field.
	function automatic logic [11:0] eff_addr(input logic [15:0] w, input logic [3:0] bank,
		input logic ext, input logic [11:0] base);
		if (w[8]) return {bank, w[7:0]};
		else if (ext && (w[7:0] <= LIT_OFS_MAX)) return base + {4'h0, w[7:0]};
		else if (w[7:0] < ACC_SPLIT) return {4'h0, w[7:0]};
		else return {ACC_HI_BANK, w[7:0]};
	endfunction

	// One-hot mask of the selected bit.
	function automatic logic [7:0] bit_mask(input logic [2:0] b);
		return 8'h01 << b;
	endfunction
endpackage
`default_nettype wire

// ### core/cies_stack.sv
// Hardware return stack that keeps the pushed return addresses.
`default_nettype none
module cies_stack
	import cies_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH,
	parameter int WIDTH = 21
) (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Push port.
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	// Top of stack.
	output logic      [WIDTH-1:0] top
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    ptr;
	logic [PW-1:0]    next_ptr;

	// The pointer wraps when the stack overflows.
	assign next_ptr = (ptr == PW'(DEPTH - 1)) ? '0 : ptr + 1'b1;
	assign top = mem[ptr];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
		end else if (push) begin
			ptr <= next_ptr;
			mem[next_ptr] <= push_data;
		end
	end
endmodule
`default_nettype wire

// ### core/cies_wdt.sv
// Watchdog counter with postscaler that the clear instruction restarts.
`default_nettype none
module cies_wdg
	import cies_pkg::*;
#(
	parameter int CNT_W  = WDG_CNT_W,
	parameter int POST_W = WDG_POST_W
) (
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Restart request.
	input  wire logic              clear,
	// Counter state.
	output logic      [CNT_W-1:0]  count,
	output logic      [POST_W-1:0] post
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			post <= '0;
		end else if (clear) begin
			count <= '0;
			post <= '0;
		end else begin
			post <= post + 1'b1;
			if (&post) begin
				count <= count + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ### core/cies_core.sv
// Execution core for a subset of the instruction set, with an APB register port.
// Notes on behaviour
// RQ1: Bit toggle inverts one bit, flags kept.
// RQ2: Toggle and clear: decode, read, process, write.
// RQ3: Access flag 0 access bank, 1 bank select.
// RQ4: Flag 0, extended, address <= 95: indexed.
// RQ5: Branch on overflow, status untouched.
// RQ6: Branch on zero, status untouched.
// RQ7: Taken branch target is PC + 2 + 2n.
// RQ8: Taken branch adds one empty cycle.
// RQ9: Call spans two words, target split.
// RQ10: Call pushes own address plus four.
// RQ11: Shadow flag copies W, status, bank.
// RQ12: Call loads 20-bit target into PC.
// RQ13: Call takes two cycles, second empty.
// RQ14: Clear writes zero and sets zero flag.
// RQ15: Clear watchdog restarts counter, sets both flags.
// RQ16: Bit index reaches bits 0 to 7.
//
// Added by the designer: register access over APB and the address map.
`default_nettype none
module cies_core
	import cies_pkg::*;
(
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Program memory.
	output logic      [20:0] pmem_addr,
	input  wire logic [15:0] pmem_rdata,
	// Data memory.
	output logic      [11:0] dmem_addr,
	input  wire logic [7:0]  dmem_rdata,
	output logic      [7:0]  dmem_wdata,
	output logic             dmem_we
);
	cies_phase_e            phase;
	cies_op_e               op;
	logic [15:0]            ir;
	logic [20:0]            pc_cur;
	logic                   flush;
	logic                   run;
	logic                   ext_en;
	logic [7:0]             status;
	logic [7:0]             wreg;
	logic [3:0]             bank_select_reg;
	logic [11:0]            index_base;
	logic [7:0]             operand;
	logic [7:0]             accumulator_shadow;
	logic [7:0]             status_shadow;
	logic [3:0]             bank_select_shadow;
	logic                   expiry_flag;
	logic                   powerdown_flag;
	logic [20:0]            stack_top;
	logic [WDG_CNT_W-1:0]   wdg_count;
	logic [WDG_POST_W-1:0]  wdg_post;
	logic                   in_q1;
	logic                   in_q2;
	logic                   in_q3;
	logic                   in_q4;
	logic                   taken;
	logic                   redirect;
	logic                   push;
	logic                   wdg_clear;
	logic [20:0]            br_target;
	logic                   apb_wr;
	logic                   pc_wr;
	logic [31:0]            rd_data;
	logic                   rd_hit;

	assign op = decode(ir);
	assign in_q1 = run && (phase == PH_Q1);
	assign in_q2 = run && (phase == PH_Q2);
	assign in_q3 = run && (phase == PH_Q3);
	assign in_q4 = run && (phase == PH_Q4);
	assign taken = in_q4 && (((op == OP_BR_OVF) && status[ST_OVF]) ||
		((op == OP_BR_ZERO) && status[ST_ZERO])); // RQ5 RQ6
	assign redirect = taken || (in_q4 && (op == OP_CALL));
	assign push = in_q3 && (op == OP_CALL); // RQ10 RQ13
	assign wdg_clear = in_q3 && (op == OP_CLEAR_WDG); // RQ15
	assign br_target = pc_cur + PC_STEP + {{12{ir[7]}}, ir[7:0], 1'b0}; // RQ7
	assign apb_wr = psel && penable && pready && pwrite;
	assign pc_wr = apb_wr && (paddr == ADDR_PC) && !run;

	// Four phases make one instruction cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= PH_Q1;
		end else if (run) begin
			case (phase)
				PH_Q1: phase <= PH_Q2;
				PH_Q2: phase <= PH_Q3;
				PH_Q3: phase <= PH_Q4;
				default: phase <= PH_Q1;
			endcase
		end
	end

	// Fetch at the end of Q4; a redirect turns the next cycle into a bubble.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ir <= NOP_WORD;
			pc_cur <= RST_PC;
			flush <= 1'b1;
		end else if (pc_wr) begin
			ir <= NOP_WORD;
			flush <= 1'b1;
		end else if (in_q4) begin
			ir <= redirect ? NOP_WORD : pmem_rdata; // RQ8 RQ13
			pc_cur <= pmem_addr;
			flush <= redirect;
		end
	end

	// Program counter.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pmem_addr <= RST_PC;
		end else if (pc_wr) begin
			pmem_addr <= pwdata[20:0];
		end else if (in_q1 && !flush) begin
			pmem_addr <= pmem_addr + PC_STEP;
		end else if (taken) begin
			pmem_addr <= br_target; // RQ7 RQ8
		end else if (in_q4 && (op == OP_CALL)) begin
			pmem_addr <= {pmem_rdata[11:0], ir[7:0], 1'b0}; // RQ9 RQ12
		end
	end

	// Data register read, process and write.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dmem_addr <= '0;
			operand <= '0;
			dmem_we <= 1'b0;
			dmem_wdata <= '0;
		end else begin
			if (in_q1) begin
				dmem_addr <= eff_addr(ir, bank_select_reg, ext_en, index_base); // RQ3 RQ4
			end
			if (in_q2) begin
				operand <= dmem_rdata; // RQ2
			end
			if (in_q3) begin
				dmem_we <= (op == OP_BIT_TOGGLE) || (op == OP_CLEAR_FILE); // RQ2
				if (op == OP_BIT_TOGGLE) begin
					dmem_wdata <= operand ^ bit_mask(ir[11:9]); // RQ1 RQ16
				end else begin
					dmem_wdata <= 8'h00; // RQ14
				end
			end else if (in_q4) begin
				dmem_we <= 1'b0;
			end
		end
	end

	// Status flags; the instruction's set wins over a software write.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= RST_STATUS;
		end else begin
			if (apb_wr && (paddr == ADDR_STATUS)) begin
				status <= pwdata[7:0];
			end
			if (in_q4 && (op == OP_CLEAR_FILE)) begin
				status[ST_ZERO] <= 1'b1; // RQ14
			end
		end
	end

	// Software configuration registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{ext_en, run} <= RST_CTRL;
			wreg <= RST_WORK;
			bank_select_reg <= RST_BANK;
			index_base <= RST_BASE;
		end else if (apb_wr) begin
			if (paddr == ADDR_CTRL) begin
				run <= pwdata[CTRL_RUN];
				ext_en <= pwdata[CTRL_EXT];
			end else if (paddr == ADDR_WORK) begin
				wreg <= pwdata[7:0];
			end else if (paddr == ADDR_BANK) begin
				bank_select_reg <= pwdata[3:0];
			end else if (paddr == ADDR_BASE) begin
				index_base <= pwdata[11:0];
			end
		end
	end

	// Shadow copies taken by a call with its save flag set.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accumulator_shadow <= '0;
			status_shadow <= '0;
			bank_select_shadow <= '0;
		end else if (push && ir[8]) begin
			accumulator_shadow <= wreg; // RQ11
			status_shadow <= status;
			bank_select_shadow <= bank_select_reg;
		end
	end

	// Watchdog flags; the clear instruction wins over a software write.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			expiry_flag <= RST_FLAG;
			powerdown_flag <= RST_FLAG;
		end else begin
			if (apb_wr && (paddr == ADDR_CORE)) begin
				expiry_flag <= pwdata[CORE_EXP];
				powerdown_flag <= pwdata[CORE_PWR];
			end
			if (wdg_clear) begin
				expiry_flag <= 1'b1; // RQ15
				powerdown_flag <= 1'b1;
			end
		end
	end

	cies_stack #(
		.DEPTH     (STACK_DEPTH),
		.WIDTH     (21)
	) u_stack (
		.clk       (pclk),
		.rst_n     (presetn),
		.push      (push),
		.push_data (pc_cur + RET_OFS), // RQ10
		.top       (stack_top)
	);

	cies_wdg #(
		.CNT_W  (WDG_CNT_W),
		.POST_W (WDG_POST_W)
	) u_wdg (
		.clk    (pclk),
		.rst_n  (presetn),
		.clear  (wdg_clear),
		.count  (wdg_count),
		.post   (wdg_post)
	);

	// Read multiplexer.
	always_comb begin
		rd_hit = 1'b1;
		if (paddr == ADDR_CTRL) rd_data = {30'h0, ext_en, run};
		else if (paddr == ADDR_STATUS) rd_data = {24'h0, status};
		else if (paddr == ADDR_WORK) rd_data = {24'h0, wreg};
		else if (paddr == ADDR_BANK) rd_data = {28'h0, bank_select_reg};
		else if (paddr == ADDR_PC) rd_data = {11'h0, pmem_addr};
		else if (paddr == ADDR_SHADOW) rd_data = {12'h0, bank_select_shadow,
			status_shadow, accumulator_shadow};
		else if (paddr == ADDR_STACK) rd_data = {11'h0, stack_top};
		else if (paddr == ADDR_CORE) rd_data = {wdg_post, wdg_count, 4'h0, phase,
			powerdown_flag, expiry_flag};
		else if (paddr == ADDR_BASE) rd_data = {20'h0, index_base};
		else begin
			rd_data = 32'h0;
			rd_hit = 1'b0;
		end
	end

	// Answer is prepared in the setup cycle, so the access phase ends at once.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pready <= 1'b1;
			pslverr <= !rd_hit;
			prdata <= pwrite ? 32'h0 : rd_data;
		end else if (pready) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_toggle_bit: assert property (dmem_we && (op == OP_BIT_TOGGLE) |-> // RQ1
		((dmem_wdata ^ operand) == bit_mask(ir[11:9]))) else $error("toggle mask wrong");
	chk_write_phase: assert property (dmem_we |-> (phase == PH_Q4)) // RQ2
		else $error("data write outside Q4");
	chk_bank_addr: assert property (in_q1 && ir[8] |=> // RQ3
		(dmem_addr == {$past(bank_select_reg), $past(ir[7:0])})) else $error("bank address");
	chk_indexed_addr: assert property (in_q1 && !ir[8] && ext_en && // RQ4
		(ir[7:0] <= LIT_OFS_MAX) |=> (dmem_addr == $past(index_base) + $past(ir[7:0])))
		else $error("indexed address");
	chk_branch_flags: assert property (in_q4 && ((op == OP_BR_OVF) || // RQ5
		(op == OP_BR_ZERO)) && !apb_wr |=> $stable(status)) else $error("branch changed flags");
	chk_branch_target: assert property (taken && !pc_wr |=> (pmem_addr == // RQ7
		$past(pc_cur) + 21'h2 + {{12{$past(ir[7])}}, $past(ir[7:0]), 1'b0}))
		else $error("branch target");
	chk_no_jump: assert property (in_q4 && (op == OP_BR_ZERO) && !status[ST_ZERO] && // RQ6
		!pc_wr |=> $stable(pmem_addr)) else $error("untaken branch moved PC");
	chk_redirect_bubble: assert property (redirect ##1 run[*3] |-> // RQ8
		(ir == NOP_WORD) && !dmem_we) else $error("bubble not empty");
	chk_call_target: assert property (in_q4 && (op == OP_CALL) && !pc_wr |=> // RQ12
		(pmem_addr == {$past(pmem_rdata[11:0]), $past(ir[7:0]), 1'b0}) ##1 flush)
		else $error("call target"); // RQ13
	chk_call_push: assert property (push |=> (stack_top == $past(pc_cur) + 21'h4)) // RQ10
		else $error("return address");
	chk_shadow_keep: assert property (push && !ir[8] |=> $stable(accumulator_shadow) && // RQ11
		$stable(status_shadow) && $stable(bank_select_shadow)) else $error("shadow changed");
	chk_clear_zero: assert property (in_q4 && (op == OP_CLEAR_FILE) |-> dmem_we && // RQ14
		(dmem_wdata == 8'h00) ##1 status[ST_ZERO]) else $error("clear failed");
	chk_wdg_clear: assert property (wdg_clear |=> (wdg_count == '0) && (wdg_post == '0) && // RQ15
		expiry_flag && powerdown_flag) else $error("watchdog clear");
endmodule
`default_nettype wire

// ### testbench/cies_mem.sv
// Program and data memory model facing the execution core.
`default_nettype none
module cies_mem (
	// Clock.
	input  wire logic        pclk,
	// Program memory.
	input  wire logic [20:0] pmem_addr,
	output logic      [15:0] pmem_rdata,
	// Data memory.
	input  wire logic [11:0] dmem_addr,
	output logic      [7:0]  dmem_rdata,
	input  wire logic [7:0]  dmem_wdata,
	input  wire logic        dmem_we
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] prog [0:4095];
	logic [7:0]  data [0:4095];
	initial begin
		for (int i = 0; i < 4096; i++) begin
			prog[i] = 16'h0000;
			data[i] = 8'h00;
		end
	end
	// Words beyond the modelled range read as no-operation.
	assign pmem_rdata = (pmem_addr[20:13] == 8'h00) ? prog[pmem_addr[12:1]] : 16'h0000;
	assign dmem_rdata = data[dmem_addr];
	always @(posedge pclk) begin
		if (dmem_we)
			data[dmem_addr] <= dmem_wdata;
	end
endmodule
`default_nettype wire

// ### testbench/tb_cpu_instr_exec_subset.sv
// Self-checking testbench of the instruction execution core.
`default_nettype none
module tb_cpu_instr_exec_subset import cies_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [7:0]  st;
		logic [20:0] pc;
		logic [15:0] w0;
		logic [15:0] w1;
		logic [11:0] a;
		logic [7:0]  init;
		logic [7:0]  exp;
		logic [7:0]  st_exp;
	} cies_row_s;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, dmem_we, err;
	logic [7:0]  paddr, dmem_rdata, dmem_wdata;
	logic [31:0] pwdata, prdata, rd;
	logic [20:0] pmem_addr;
	logic [15:0] pmem_rdata;
	logic [11:0] dmem_addr;
	int          fails, n_compared, cycles;
	cies_row_s   rows [8] = '{
		'{8'h00, 21'h0, 16'h7810, 16'h0000, 12'h010, 8'h75, 8'h65, 8'h00},
		'{8'h00, 21'h0, 16'h7E10, 16'h0000, 12'h010, 8'h00, 8'h80, 8'h00},
		'{8'h00, 21'h0, 16'h70F0, 16'h0000, 12'hFF0, 8'h00, 8'h01, 8'h00},
		'{8'h00, 21'h0, 16'h6A10, 16'h0000, 12'h010, 8'h5A, 8'h00, 8'h04},
		'{8'h04, 21'h0, 16'hE001, 16'h7010, 12'h010, 8'h00, 8'h00, 8'h04},
		'{8'h00, 21'h0, 16'hE001, 16'h7010, 12'h010, 8'h00, 8'h01, 8'h00},
		'{8'h08, 21'h200, 16'hE480, 16'h7010, 12'h010, 8'h00, 8'h00, 8'h08},
		'{8'h04, 21'h0, 16'hE401, 16'h7010, 12'h010, 8'h00, 8'h01, 8'h04}
	};

	cies_core u_cies_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .pmem_addr, .pmem_rdata, .dmem_addr, .dmem_rdata,
		.dmem_wdata, .dmem_we);
	cies_mem u_cies_mem (.pclk, .pmem_addr, .pmem_rdata, .dmem_addr, .dmem_rdata,
		.dmem_wdata, .dmem_we);

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic test_done;
		if (fails == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			fails++;
			test_done();
		end
	end

	task automatic check(input logic ok, input string msg);
		n_compared++;
		if (ok !== 1'b1) begin
			fails++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask

	// One APB transfer; waits for pready at the sampling edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string s);
		apb(1'b0, a, 32'h0);
		check(((rd & m) === e) && (err === 1'b0), s);
	endtask

	task automatic run(input logic [20:0] pc, input logic ext);
		apb(1'b1, ADDR_PC, {11'h000, pc});
		apb(1'b1, ADDR_CTRL, {30'h0, ext, 1'b1});
		repeat (48) @(posedge pclk);
		apb(1'b1, ADDR_CTRL, {30'h0, ext, 1'b0});
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fails = 0;
		n_compared = 0;
		cycles = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rdc(ADDR_CTRL, 32'h3, 32'h0, "control reset value");
		rdc(ADDR_CORE, 32'h3, 32'h3, "core flags reset value");
		apb(1'b0, 8'h40, 32'h0);
		check(err === 1'b1 && rd === 32'h0, "unmapped read");
		foreach (rows[i]) begin
			apb(1'b1, ADDR_STATUS, {24'h0, rows[i].st});
			u_cies_mem.data[rows[i].a] = rows[i].init;
			u_cies_mem.prog[rows[i].pc[12:1]] = rows[i].w0;
			u_cies_mem.prog[rows[i].pc[12:1] + 12'h001] = rows[i].w1;
			run(rows[i].pc, 1'b0);
			check(u_cies_mem.data[rows[i].a] === rows[i].exp, "row data");
			rdc(ADDR_STATUS, 32'hFF, {24'h0, rows[i].st_exp}, "row status");
			u_cies_mem.prog[rows[i].pc[12:1]] = 16'h0000;
			u_cies_mem.prog[rows[i].pc[12:1] + 12'h001] = 16'h0000;
		end
		// Indexed literal offset against the access bank boundary.
		apb(1'b1, ADDR_BASE, 32'h100);
		u_cies_mem.prog[0] = 16'h7005;
		u_cies_mem.prog[1] = 16'h7260;
		u_cies_mem.data[12'h105] = 8'h00;
		u_cies_mem.data[12'hF60] = 8'h00;
		run(21'h0, 1'b1);
		check(u_cies_mem.data[12'h105] === 8'h01, "indexed toggle");
		check(u_cies_mem.data[12'hF60] === 8'h02, "access bank above split");
		// Two-word call with shadow save.
		apb(1'b1, ADDR_WORK, 32'h12);
		apb(1'b1, ADDR_BANK, 32'h3);
		apb(1'b1, ADDR_STATUS, 32'h08);
		u_cies_mem.prog[0] = 16'hED10;
		u_cies_mem.prog[1] = 16'hF00F;
		u_cies_mem.prog[12'hF10] = 16'h7410;
		u_cies_mem.prog[12'hF11] = 16'h7310;
		u_cies_mem.data[12'h010] = 8'h00;
		u_cies_mem.data[12'h310] = 8'h00;
		run(21'h0, 1'b0);
		rdc(ADDR_STACK, 32'h1FFFFF, 32'h4, "return address");
		rdc(ADDR_SHADOW, 32'hFFFFF, 32'h30812, "shadow copy");
		rdc(ADDR_STATUS, 32'hFF, 32'h08, "call keeps status");
		check(u_cies_mem.data[12'h010] === 8'h04, "call target");
		check(u_cies_mem.data[12'h310] === 8'h02, "bank select toggle");
		// Call without shadow save from a nonzero address.
		apb(1'b1, ADDR_WORK, 32'h55);
		u_cies_mem.prog[12'h020] = 16'hEC10;
		u_cies_mem.prog[12'h021] = 16'hF00F;
		run(21'h40, 1'b0);
		rdc(ADDR_STACK, 32'h1FFFFF, 32'h44, "second return address");
		rdc(ADDR_SHADOW, 32'hFFFFF, 32'h30812, "shadows kept");
		// Watchdog clear sets both flags again.
		apb(1'b1, ADDR_CORE, 32'h0);
		rdc(ADDR_CORE, 32'h3, 32'h0, "flags written low");
		u_cies_mem.prog[0] = 16'h0004;
		run(21'h0, 1'b0);
		rdc(ADDR_CORE, 32'h3, 32'h3, "watchdog clear flags");
		// A reset in the middle of a run brings the control, PC, status, work, stack and core registers back.
		apb(1'b1, ADDR_CORE, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h3);
		repeat (10) @(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc(ADDR_CTRL, 32'h3, 32'h0, "control after reset");
		rdc(ADDR_PC, 32'h1FFFFF, 32'h0, "program counter after reset");
		rdc(ADDR_STATUS, 32'hFF, 32'h0, "status after reset");
		rdc(ADDR_WORK, 32'hFF, 32'h0, "work register after reset");
		rdc(ADDR_STACK, 32'h1FFFFF, 32'h0, "stack after reset");
		rdc(ADDR_CORE, 32'hF, 32'h3, "flags and phase after reset");
		test_done();
	end
endmodule
`default_nettype wire
